// *** dv/sepc_host.sv ***
// host-side model that drives the serial pins and reports what it reads back
`timescale 1ns/1ps
module sepc_host
    import sepc_pkg::*;
(
    // clock
    input wire logic i_core_clk,
    // device pins
    input wire logic i_serial_out,
    input wire logic i_serial_out_en,
    output logic o_select,
    output logic o_serial_clock,
    output logic o_serial_in,
    // observed results
    output logic o_res_valid,
    output logic [17:0] o_res_data
);
    initial begin
        o_select = 1'b0;
        o_serial_clock = 1'b0;
        o_serial_in = 1'b0;
        o_res_valid = 1'b0;
        o_res_data = 18'h00000;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(negedge i_core_clk);
    endtask

    // six-cycle phases leave margin over the two-flop synchroniser
    task automatic put_bit(input logic b, output logic [1:0] seen);
        o_serial_in = b;
        wait_clk(6);
        o_serial_clock = 1'b1;
        wait_clk(6);
        // a released pin reads as the inverse of its last bit, so it never looks valid
        seen = {i_serial_out_en, i_serial_out_en ? i_serial_out : ~i_serial_out};
        o_serial_clock = 1'b0;
    endtask

    task automatic report(input logic [17:0] v);
        o_res_data = v;
        o_res_valid = 1'b1;
        wait_clk(1);
        o_res_valid = 1'b0;
        wait_clk(1);
    endtask

    // data line gets the inverse of its last value so a stale bit never looks valid
    task automatic end_frame();
        o_select = 1'b0;
        o_serial_in = ~o_serial_in;
        wait_clk(8);
    endtask

    task automatic send(input logic [1:0] op, input logic [8:0] addr, input int na,
                        input logic [15:0] data, input int nd, output logic [1:0] last);
        o_select = 1'b1;
        wait_clk(2);
        put_bit(1'b1, last);
        for (int i = 1; i >= 0; i--) put_bit(op[i], last);
        for (int i = na - 1; i >= 0; i--) put_bit(addr[i], last);
        for (int i = nd - 1; i >= 0; i--) put_bit(data[i], last);
    endtask

    task automatic read(input logic [8:0] addr, input int na, input int nd);
        logic [1:0] s;
        logic [1:0] b;
        logic [15:0] w;
        w = 16'h0000;
        send(OPC_READ, addr, na, 16'h0000, 0, s);
        for (int i = 0; i < nd; i++) begin
            put_bit(1'b0, b);
            w = {w[14:0], b[0]};
        end
        end_frame();
        report({s, w});
    endtask

    task automatic poll();
        logic [1:0] s;
        int n;
        o_select = 1'b1;
        wait_clk(8);
        s = {i_serial_out_en, i_serial_out & i_serial_out_en};
        report({s, 16'h0000});
        n = 0;
        while (s === 2'b10 && n < 300) begin
            wait_clk(4);
            s = {i_serial_out_en, i_serial_out};
            n++;
        end
        if (s[1] === 1'b1) begin
            report({s, 16'h0000});
            put_bit(1'b1, s);
        end
        end_frame();
    endtask
endmodule

// *** dv/tb.sv ***
// self-checking bench for the serial eeprom program control block
`timescale 1ns/1ps
module tb;
    import sepc_pkg::*;
    localparam int PROG = 400;
    logic clk, rst, wsel, sel, sck, sdi, sdo, sdo_en, res_valid;
    logic [17:0] res_data;
    logic [17:0] exp_q[$];
    logic [17:0] want;
    logic [15:0] r1, r2, r3;
    int n_fail, n_tests, cycles, seed;

    sepc_ctrl #(.PROG_CYCLES(PROG), .DEPTH(2)) dut_u (
        .i_core_clk(clk), .i_rst(rst), .i_select(sel), .i_serial_clock(sck),
        .i_serial_in(sdi), .i_word_width_select(wsel), .o_serial_out(sdo),
        .o_serial_out_en(sdo_en));
    sepc_host host_u (
        .i_core_clk(clk), .i_serial_out(sdo), .i_serial_out_en(sdo_en), .o_select(sel),
        .o_serial_clock(sck), .o_serial_in(sdi), .o_res_valid(res_valid),
        .o_res_data(res_data));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic test_done();
        if (exp_q.size() != 0) begin
            n_fail++;
            $display("[FAIL] pending results expected 0 seen %0d", exp_q.size());
        end
        if (n_fail == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // the watcher pairs each reported result with the oldest expectation
    always @(posedge clk) begin
        cycles++;
        if (res_valid === 1'b1) begin
            n_tests++;
            want = (exp_q.size() != 0) ? exp_q.pop_front() : 18'h3FFFF;
            if (res_data !== want) begin
                n_fail++;
                $display("[FAIL] result expected %h seen %h", want, res_data);
            end
        end
        if (cycles > 60000) begin
            n_fail++;
            $display("[FAIL] timeout expected %0d seen %0d", 60000, cycles);
            test_done();
        end
    end

    task automatic cmd(input logic [1:0] op, input logic [8:0] a, input logic [15:0] d,
                       input logic with_data);
        logic [1:0] s;
        host_u.send(op, a, wsel ? 8 : 9, d, with_data ? (wsel ? 16 : 8) : 0, s);
        host_u.end_frame();
    endtask

    task automatic ext(input logic [1:0] e, input logic [15:0] d);
        cmd(OPC_EXT, wsel ? {1'b0, e, 6'h00} : {e, 7'h00}, d, e == EXT_WRITE_ALL);
    endtask

    task automatic chk_rd(input logic [8:0] a, input logic [15:0] w);
        exp_q.push_back({2'b10, w});
        host_u.read(a, wsel ? 8 : 9, wsel ? 16 : 8);
    endtask

    // a launched cycle shows busy then ready; a refused one never drives the pin
    task automatic chk_poll(input logic launched);
        if (launched) begin
            exp_q.push_back(18'h20000);
            exp_q.push_back(18'h30000);
        end else begin
            exp_q.push_back(18'h00000);
        end
        host_u.poll();
    endtask

    initial begin
        seed = 90;
        n_fail = 0;
        n_tests = 0;
        cycles = 0;
        rst = 1'b1;
        wsel = 1'b1;
        repeat (10) @(negedge clk);
        rst = 1'b0;
        repeat (4) @(negedge clk);
        r1 = 16'($random(seed));
        r2 = 16'($random(seed));
        r3 = 16'($random(seed));
        cmd(OPC_WRITE, 9'h005, r1, 1'b1);
        chk_poll(1'b0);
        chk_rd(9'h005, ERASED_WORD);
        ext(EXT_ENABLE, 16'h0000);
        cmd(OPC_WRITE, 9'h005, r1, 1'b1);
        chk_poll(1'b1);
        chk_rd(9'h005, r1);
        cmd(OPC_WRITE, 9'h005, r2, 1'b1);
        cmd(OPC_ERASE, 9'h005, 16'h0000, 1'b0);
        chk_poll(1'b1);
        chk_rd(9'h005, r2);
        cmd(OPC_ERASE, 9'h005, 16'h0000, 1'b0);
        chk_poll(1'b1);
        chk_rd(9'h005, ERASED_WORD);
        ext(EXT_WRITE_ALL, r3);
        chk_poll(1'b1);
        chk_rd(9'h000, r3);
        chk_rd(9'h0FF, r3);
        ext(EXT_ERASE_ALL, 16'h0000);
        chk_poll(1'b1);
        chk_rd(9'h007, ERASED_WORD);
        // byte organisation: odd address is the high byte of the word
        wsel = 1'b0;
        cmd(OPC_WRITE, 9'h00B, {8'h00, r1[7:0]}, 1'b1);
        chk_poll(1'b1);
        chk_rd(9'h00B, {8'h00, r1[7:0]});
        chk_rd(9'h00A, 16'h00FF);
        wsel = 1'b1;
        chk_rd(9'h005, {r1[7:0], 8'hFF});
        ext(EXT_DISABLE, 16'h0000);
        for (int i = 0; i < 4; i++) begin
            case (i)
                0: cmd(OPC_WRITE, 9'h005, r2, 1'b1);
                1: cmd(OPC_ERASE, 9'h005, 16'h0000, 1'b0);
                2: ext(EXT_ERASE_ALL, 16'h0000);
                default: ext(EXT_WRITE_ALL, r2);
            endcase
            chk_poll(1'b0);
        end
        chk_rd(9'h005, {r1[7:0], 8'hFF});
        repeat (4) @(negedge clk);
        test_done();
    end
endmodule

// *** logic/sepc_ctrl.sv ***
// serial eeprom instruction decoder, program-enable latch and self-timed program engine
`timescale 1ns/1ps
module sepc_ctrl #(
    parameter int PROG_CYCLES = sepc_pkg::PROG_CYCLES,
    parameter int DEPTH = 2
) (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst,
    // serial pins
    input wire logic i_select,
    input wire logic i_serial_clock,
    input wire logic i_serial_in,
    input wire logic i_word_width_select,
    output logic o_serial_out,
    output logic o_serial_out_en
);
    import sepc_pkg::*;

    localparam int HALF = PROG_CYCLES / 2;
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    // pin synchroniser; edge detectors only look at the second stage
    sepc_pins_t sync1, sync2, prev;
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            sync1 <= '0;
            sync2 <= '0;
            prev <= '0;
        end else begin
            sync1 <= {i_select, i_serial_clock, i_serial_in, i_word_width_select};
            sync2 <= sync1;
            prev <= sync2;
        end
    end
    logic sck_rise, cs_fall;
    assign sck_rise = sync2.sclk && !prev.sclk;
    assign cs_fall = !sync2.select && prev.select;

    typedef enum logic [1:0] {DEC_IDLE, DEC_HDR, DEC_DATA, DEC_DONE} sepc_dec_t;
    typedef enum logic [1:0] {ENG_IDLE, ENG_CLEAR, ENG_STORE} sepc_eng_t;

    logic [15:0] mem [WORDS];
    sepc_eng_t eng, next_eng;
    logic [31:0] eng_cnt, next_eng_cnt;
    sepc_cmd_t cur, next_cur;
    logic busy;

    // two-entry command buffer between decoder and engine
    sepc_cmd_t fifo [DEPTH];
    logic [PW-1:0] wptr, rptr, next_wptr, next_rptr;
    logic [PW:0] fcnt, next_fcnt;
    logic push_valid, push_ready, pop_valid, pop_ready;
    sepc_cmd_t push_cmd;
    assign push_ready = (fcnt < (PW+1)'(DEPTH));
    assign pop_valid = (fcnt != '0);
    assign pop_ready = (eng == ENG_IDLE);
    assign busy = (eng != ENG_IDLE) || pop_valid;

    always_comb begin
        next_wptr = wptr;
        next_rptr = rptr;
        next_fcnt = fcnt;
        if (push_valid && push_ready) begin
            next_wptr = (wptr == PW'(DEPTH-1)) ? '0 : wptr + 1'b1;
        end
        if (pop_valid && pop_ready) begin
            next_rptr = (rptr == PW'(DEPTH-1)) ? '0 : rptr + 1'b1;
        end
        next_fcnt = fcnt + (PW+1)'(push_valid && push_ready) - (PW+1)'(pop_valid && pop_ready);
    end
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            wptr <= '0;
            rptr <= '0;
            fcnt <= '0;
            for (int k = 0; k < DEPTH; k++) begin
                fifo[k] <= '0;
            end
        end else begin
            wptr <= next_wptr;
            rptr <= next_rptr;
            fcnt <= next_fcnt;
            if (push_valid && push_ready) begin
                fifo[wptr] <= push_cmd;
            end
        end
    end

    // decoder and enable latch
    sepc_dec_t dec, next_dec;
    logic [4:0] bcnt, next_bcnt;
    logic [10:0] hdr, next_hdr;
    logic [15:0] dat, next_dat;
    logic wsel16, next_wsel16;
    logic en, next_en;
    logic status_mode, next_status_mode;
    logic rd_active, next_rd_active;
    logic [16:0] rd_sr, next_rd_sr;
    logic [10:0] hdr_nx;
    logic [1:0] opc, ext;
    logic [8:0] addr;
    logic [7:0] widx_rd;
    logic [4:0] hdr_len, dat_len;

    assign hdr_nx = {hdr[9:0], sync2.sin};
    assign hdr_len = wsel16 ? HDR_LEN_X16 : HDR_LEN_X8;
    assign dat_len = wsel16 ? DAT_LEN_X16 : DAT_LEN_X8;
    assign opc = wsel16 ? hdr[9:8] : hdr[10:9];
    assign addr = wsel16 ? {1'b0, hdr[7:0]} : hdr[8:0];
    assign ext = wsel16 ? addr[7:6] : addr[8:7];
    assign widx_rd = wsel16 ? hdr_nx[7:0] : hdr_nx[8:1];

    always_comb begin
        next_dec = dec;
        next_bcnt = bcnt;
        next_hdr = hdr;
        next_dat = dat;
        next_wsel16 = wsel16;
        next_en = en;
        next_status_mode = status_mode;
        next_rd_active = rd_active;
        next_rd_sr = rd_sr;
        push_valid = 1'b0;
        push_cmd = '{op: SEPC_OP_WRITE, byte_mode: !wsel16, addr: addr, data: dat};
        if (cs_fall) begin
            next_dec = DEC_IDLE;
            next_rd_active = 1'b0;
            if (dec == DEC_DONE) begin
                if (opc == OPC_EXT && ext == EXT_ENABLE) begin
                    next_en = 1'b1;
                end else if (opc == OPC_EXT && ext == EXT_DISABLE) begin
                    next_en = 1'b0; // see RL3
                end
                if (opc == OPC_WRITE) begin
                    push_cmd.op = SEPC_OP_WRITE;
                end else if (opc == OPC_ERASE) begin
                    push_cmd.op = SEPC_OP_ERASE;
                end else if (ext == EXT_ERASE_ALL) begin
                    push_cmd.op = SEPC_OP_ERASE_ALL;
                end else begin
                    push_cmd.op = SEPC_OP_WRITE_ALL;
                end
                // refused while disabled: no cycle, no status; see RL1 see RL4 see RL19
                push_valid = en && (opc == OPC_WRITE || opc == OPC_ERASE ||
                    (opc == OPC_EXT && (ext == EXT_ERASE_ALL || ext == EXT_WRITE_ALL)));
                // select fall launches the timed cycle; see RL7 see RL11 see RL12 see RL13
                next_status_mode = push_valid && push_ready;
            end
        end else if (!sync2.select) begin
            next_dec = DEC_IDLE;
        end else if (sck_rise && !busy) begin // see RL18 see RL20
            case (dec)
                DEC_IDLE: begin
                    if (sync2.sin) begin // see RL15
                        next_dec = DEC_HDR;
                        next_bcnt = '0;
                        next_wsel16 = sync2.wsel;
                        // a dummy start bit also releases serial out from status
                        next_status_mode = 1'b0;
                    end
                end
                DEC_HDR: begin
                    next_hdr = hdr_nx;
                    next_bcnt = bcnt + 5'h01;
                    if (bcnt == hdr_len - 5'h01) begin
                        next_bcnt = '0;
                        next_dec = DEC_DONE;
                        // see RL16
                        if ((wsel16 ? hdr_nx[9:8] : hdr_nx[10:9]) == OPC_READ) begin
                            // read ignores the enable latch; see RL5
                            next_rd_active = 1'b1;
                            next_rd_sr = {1'b0, mem[widx_rd]};
                            if (!wsel16) begin
                                next_rd_sr = {1'b0, hdr_nx[0] ? mem[widx_rd][15:8]
                                    : mem[widx_rd][7:0], 8'h00};
                            end
                        end else if ((wsel16 ? hdr_nx[9:8] : hdr_nx[10:9]) == OPC_WRITE ||
                            (wsel16 ? hdr_nx[9:6] : hdr_nx[10:7]) == {OPC_EXT, EXT_WRITE_ALL}) begin
                            next_dec = DEC_DATA;
                        end
                    end
                end
                DEC_DATA: begin
                    next_dat = {dat[14:0], sync2.sin};
                    next_bcnt = bcnt + 5'h01;
                    if (bcnt == dat_len - 5'h01) begin
                        next_dec = DEC_DONE;
                    end
                end
                default: begin
                    next_rd_sr = {rd_sr[15:0], 1'b0};
                end
            endcase
        end
    end
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            dec <= DEC_IDLE;
            bcnt <= '0;
            hdr <= '0;
            dat <= '0;
            wsel16 <= 1'b1;
            en <= 1'b0; // see RL1
            status_mode <= 1'b0;
            rd_active <= 1'b0;
            rd_sr <= '0;
        end else begin
            dec <= next_dec;
            bcnt <= next_bcnt;
            hdr <= next_hdr;
            dat <= next_dat;
            wsel16 <= next_wsel16;
            en <= next_en;
            status_mode <= next_status_mode;
            rd_active <= next_rd_active;
            rd_sr <= next_rd_sr;
        end
    end

    // serial out: read data first, otherwise ready/busy while polled
    logic next_out, next_out_en;
    always_comb begin
        next_out_en = sync2.select && (rd_active || status_mode); // see RL9
        next_out = rd_active ? rd_sr[16] : !busy; // see RL17
    end
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            o_serial_out <= 1'b0;
            o_serial_out_en <= 1'b0;
        end else begin
            o_serial_out <= next_out;
            o_serial_out_en <= next_out_en;
        end
    end

    // program engine: runs on the core clock alone, no serial clock needed; see RL8
    logic clear_end, store_end;
    logic [15:0] wmask, wval;
    logic [7:0] widx;
    logic all_op;
    assign all_op = (cur.op == SEPC_OP_ERASE_ALL) || (cur.op == SEPC_OP_WRITE_ALL);
    assign widx = cur.byte_mode ? cur.addr[8:1] : cur.addr[7:0];

    always_comb begin
        next_eng = eng;
        next_eng_cnt = eng_cnt;
        next_cur = cur;
        clear_end = 1'b0;
        store_end = 1'b0;
        case (eng)
            ENG_IDLE: begin
                if (pop_valid) begin
                    next_cur = fifo[rptr];
                    next_eng = ENG_CLEAR;
                    next_eng_cnt = '0;
                end
            end
            ENG_CLEAR: begin
                next_eng_cnt = eng_cnt + 32'h1;
                if (eng_cnt == 32'(HALF - 1)) begin
                    clear_end = 1'b1;
                    next_eng_cnt = '0;
                    // auto-clear comes before every store; see RL10 see RL14
                    next_eng = (cur.op == SEPC_OP_WRITE || cur.op == SEPC_OP_WRITE_ALL)
                        ? ENG_STORE : ENG_IDLE;
                end
            end
            default: begin
                next_eng_cnt = eng_cnt + 32'h1;
                if (eng_cnt == 32'(PROG_CYCLES - HALF - 1)) begin
                    store_end = 1'b1;
                    next_eng = ENG_IDLE;
                end
            end
        endcase
        wmask = ERASED_WORD;
        if (cur.byte_mode && !all_op) begin
            wmask = cur.addr[0] ? MASK_HI : MASK_LO;
        end
        wval = cur.byte_mode ? {cur.data[7:0], cur.data[7:0]} : cur.data;
        if (clear_end) begin
            wval = ERASED_WORD;
        end
    end
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            eng <= ENG_IDLE;
            eng_cnt <= '0;
            cur <= '0;
        end else begin
            eng <= next_eng;
            eng_cnt <= next_eng_cnt;
            cur <= next_cur;
        end
    end

    // storage array, one entry per generate step
    for (genvar i = 0; i < WORDS; i++) begin : g_word
        logic [15:0] next_word;
        always_comb begin
            next_word = mem[i];
            if ((clear_end || store_end) && (all_op || widx == 8'(i))) begin
                next_word = (mem[i] & ~wmask) | (wval & wmask);
            end
        end
        always_ff @(posedge i_core_clk or posedge i_rst) begin
            if (i_rst) begin
                mem[i] <= ERASED_WORD;
            end else begin
                mem[i] <= next_word;
            end
        end
    end

    property p_latch_reset;
        @(posedge i_core_clk) $fell(i_rst) |-> !en;
    endproperty
    a_latch_reset: assert property (p_latch_reset) else $error("latch set after reset"); // see RL1

    property p_latch_hold;
        @(posedge i_core_clk) disable iff (i_rst)
        $fell(en) |-> $past(cs_fall && dec == DEC_DONE && opc == OPC_EXT && ext == EXT_DISABLE);
    endproperty
    a_latch_hold: assert property (p_latch_hold) else $error("latch lost without disable"); // see RL3

    property p_refuse;
        @(posedge i_core_clk) disable iff (i_rst)
        (!en && !busy) |=> !busy;
    endproperty
    a_refuse: assert property (p_refuse) else $error("cycle launched while disabled"); // see RL19

    property p_no_accept_busy;
        @(posedge i_core_clk) disable iff (i_rst)
        (busy && dec == DEC_IDLE && sync2.select) |=> dec == DEC_IDLE;
    endproperty
    a_no_accept_busy: assert property (p_no_accept_busy) else $error("input taken busy"); // see RL20

    property p_sample;
        @(posedge i_core_clk) disable iff (i_rst)
        (sck_rise && sync2.select && !cs_fall && !busy && dec == DEC_DATA) |=>
            dat[0] == $past(sync2.sin);
    endproperty
    a_sample: assert property (p_sample) else $error("data bit not sampled"); // see RL18

    property p_status;
        @(posedge i_core_clk) disable iff (i_rst)
        (sync2.select && status_mode && !rd_active) |=>
            o_serial_out_en && o_serial_out == !$past(busy);
    endproperty
    a_status: assert property (p_status) else $error("status not driven"); // see RL17

    property p_erase_word;
        @(posedge i_core_clk) disable iff (i_rst)
        (clear_end && cur.op == SEPC_OP_ERASE && !cur.byte_mode) |=>
            mem[cur.addr[7:0]] == ERASED_WORD && eng == ENG_IDLE;
    endproperty
    a_erase_word: assert property (p_erase_word) else $error("erase left zeros"); // see RL11

    property p_erase_all;
        @(posedge i_core_clk) disable iff (i_rst)
        (clear_end && cur.op == SEPC_OP_ERASE_ALL) |=>
            mem[0] == ERASED_WORD && mem[WORDS-1] == ERASED_WORD;
    endproperty
    a_erase_all: assert property (p_erase_all) else $error("erase all incomplete"); // see RL12

    property p_write_word;
        @(posedge i_core_clk) disable iff (i_rst)
        (store_end && cur.op == SEPC_OP_WRITE && !cur.byte_mode) |=>
            mem[cur.addr[7:0]] == cur.data;
    endproperty
    a_write_word: assert property (p_write_word) else $error("write data wrong"); // see RL7

    property p_write_all;
        @(posedge i_core_clk) disable iff (i_rst)
        (store_end && cur.op == SEPC_OP_WRITE_ALL && !cur.byte_mode) |=>
            mem[0] == cur.data && mem[WORDS-1] == cur.data;
    endproperty
    a_write_all: assert property (p_write_all) else $error("write all data wrong"); // see RL13

    property p_clear_len;
        @(posedge i_core_clk) disable iff (i_rst)
        (eng == ENG_CLEAR) |-> eng_cnt < 32'(HALF);
    endproperty
    a_clear_len: assert property (p_clear_len) else $error("clear phase overran"); // see RL8
endmodule

// *** logic/sepc_pkg.sv ***
// constants and types for the serial eeprom program control block
// Behaviour
// RL1: reset clears the program-enable latch; modifying instructions refused until enabled
// RL2: host sends program enable before any modifying instruction after reset or disable
// RL3: enable latch stays set until reset or a program-disable instruction
// RL4: while disabled, write, erase, erase-all and write-all leave memory untouched
// RL5: read returns stored data whether the enable latch is set or not
// RL6: host holds select low at least the minimum select low time after modifying
// RL7: write starts on select fall; timed cycle clears the word, then stores data
// RL8: a started internal cycle finishes without further serial clock edges
// RL9: host raises select and samples serial out; device drives ready/busy there
// RL10: write gives correct data without prior erase, thanks to the automatic clear
// RL11: erase starts on select fall and leaves every bit of the word at one
// RL12: erase-all starts on select fall and leaves every array bit at one
// RL13: write-all starts on select fall and stores one data word everywhere
// RL14: write-all is correct without a prior erase of the array
// RL15: frame is start bit, 2-bit opcode, 8 or 9 address bits, 16 or 8 data
// RL16: read 10, erase 11, write 01; 00 with address top bits 11,00,10,01
// RL17: polled serial out is low while the cycle runs and high when ready
// RL18: serial in is sampled on each rising serial clock edge
// RL19: refused modifying instruction starts no cycle and shows no busy afterwards
// RL20: during an internal cycle no instruction is accepted; only status is reported
package sepc_pkg;
    localparam int CLK_PERIOD_NS = 100;
    localparam int T_PROG_MS = 5;
    // longest programming time, rounded down to whole clock cycles
    localparam int PROG_CYCLES = (T_PROG_MS * 1000000) / CLK_PERIOD_NS;
    localparam int WORDS = 256;
    localparam int WORD_W = 16;
    localparam int ADDR_W = 9;
    localparam logic [4:0] HDR_LEN_X16 = 5'h0A;
    localparam logic [4:0] HDR_LEN_X8 = 5'h0B;
    localparam logic [4:0] DAT_LEN_X16 = 5'h10;
    localparam logic [4:0] DAT_LEN_X8 = 5'h08;
    localparam logic [1:0] OPC_EXT = 2'h0;
    localparam logic [1:0] OPC_WRITE = 2'h1;
    localparam logic [1:0] OPC_READ = 2'h2;
    localparam logic [1:0] OPC_ERASE = 2'h3;
    localparam logic [1:0] EXT_DISABLE = 2'h0;
    localparam logic [1:0] EXT_WRITE_ALL = 2'h1;
    localparam logic [1:0] EXT_ERASE_ALL = 2'h2;
    localparam logic [1:0] EXT_ENABLE = 2'h3;
    localparam logic [15:0] ERASED_WORD = 16'hFFFF;
    localparam logic [15:0] MASK_LO = 16'h00FF;
    localparam logic [15:0] MASK_HI = 16'hFF00;
    typedef enum logic [1:0] {
        SEPC_OP_WRITE, SEPC_OP_ERASE, SEPC_OP_ERASE_ALL, SEPC_OP_WRITE_ALL
    } sepc_op_t;
    typedef struct packed {
        sepc_op_t op;
        logic byte_mode;
        logic [8:0] addr;
        logic [15:0] data;
    } sepc_cmd_t;
    typedef struct packed {
        logic select;
        logic sclk;
        logic sin;
        logic wsel;
    } sepc_pins_t;
endpackage
